/* File: hw/lfc_lin_node.sv */
// LIN frame control registers: data bytes 4-8, command, status, fault and size registers.
// Assumes an external bus timing engine gives synchronous one-cycle event pulses.
`timescale 1ns/1ps
module lfc_lin_node import lfc_pkg::*; #(
	parameter longint unsigned IDLE_CYCLES = LFC_IDLE_TIMEOUT_CYC
) (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	lfc_link_if.dev lnk,
	input wire logic master_mode_in,
	input wire logic bus_active_in,
	input wire logic sync_break_in,
	input wire logic id_received_in,
	input wire logic [5:0] frame_id_in,
	input wire logic frame_done_in,
	input wire logic first_byte_done_in,
	input wire logic sync_fault_in,
	input wire logic parity_fault_in,
	input wire logic timeout_in,
	input wire logic checksum_fault_in,
	input wire logic tx_driving_in,
	input wire logic tx_bit_in,
	input wire logic rx_bit_in,
	input wire logic wake_sent_in,
	input wire logic wake_rx_in,
	input wire logic rx_byte_valid_in,
	input wire logic [2:0] rx_byte_pos_in,
	input wire logic [7:0] rx_byte_in,
	output logic frame_direction_out,
	output logic master_frame_start_out,
	output logic wake_signal_request_out,
	output logic slave_data_ack_out,
	output logic stop_pulse_out,
	output logic suspended_out,
	output logic sleep_warning_out,
	output logic enhanced_checksum_select_out,
	output logic [3:0] data_len_out,
	output logic [LFC_DATA_BYTES*8-1:0] data_bytes_out
);
	localparam int CW = $clog2(IDLE_CYCLES + 1);
	localparam logic [CW-1:0] IDLE_LIMIT = CW'(IDLE_CYCLES);

	typedef struct packed {
		logic done;
		logic [7:0] rdata;
		logic [7:0] index;
		logic [LFC_DATA_BYTES-1:0][7:0] data;
		logic dir;
		logic sleep;
		logic ack_pulse;
		logic stop_pulse;
		logic start_req;
		logic wake_req;
		logic suspended;
		logic active;
		logic idle_to;
		logic abort;
		logic identifier_received;
		logic irq;
		logic err;
		logic wake_seen;
		logic done_flag;
		logic busy;
		logic acked;
		logic [4:0] fault;
		logic enh;
		logic [3:0] len;
		logic [3:0] dlen;
		logic [CW-1:0] idle_cnt;
	} lfc_dev_state_s;

	lfc_dev_state_s q_reg;
	lfc_dev_state_s q_next;

	// ==========================================
	// Data length decode
	function automatic logic [3:0] lfc_decode_len(input logic [3:0] code, input logic [5:0] id);
		logic [3:0] len;
		len = 4'h0;
		if (code <= LFC_LEN_MAX) begin
			len = code; // see R22
		end else if (code == LFC_LEN_FROM_ID) begin
			unique case (id[5:4]) // see R23
				2'h0, 2'h1: len = LFC_LEN_TWO;
				2'h2: len = LFC_LEN_FOUR;
				2'h3: len = LFC_LEN_EIGHT;
			endcase
		end
		return len;
	endfunction

	// ==========================================
	// Next state
	always_comb begin
		logic slave;
		logic acc;
		logic wwin;
		logic in_data;
		logic [2:0] pos;
		logic [7:0] wd;
		logic [4:0] fset;
		logic [7:0] rd;
		slave = !master_mode_in;
		rd = 8'h00;
		fset = 5'h00;
		acc = lnk.acc_valid && !q_reg.done;
		wwin = acc && lnk.acc_write && lnk.acc_sel;
		wd = lnk.acc_wdata;
		in_data = (q_reg.index >= LFC_IDX_DATA4) && (q_reg.index <= LFC_IDX_DATA8);
		pos = 3'(q_reg.index - LFC_IDX_DATA4);
		q_next = q_reg;
		q_next.done = acc;
		q_next.ack_pulse = 1'b0;
		q_next.stop_pulse = 1'b0;
		q_next.active = bus_active_in; // see R10

		// Register read mux, one cycle behind the request
		if (!lnk.acc_sel) begin
			rd = q_reg.index;
		end else if (in_data) begin
			rd = q_reg.data[pos];
		end else begin
			unique case (q_reg.index)
				LFC_IDX_CTRL: rd = {2'h0, q_reg.dir, q_reg.ack_pulse, 2'h0, q_reg.wake_req, q_reg.start_req};
				LFC_IDX_STAT: rd = {q_reg.active, q_reg.idle_to, q_reg.abort, q_reg.identifier_received, q_reg.irq,
					q_reg.err, q_reg.wake_req | q_reg.wake_seen, q_reg.done_flag}; // see R15
				LFC_IDX_FAULT: rd = {3'h0, q_reg.fault}; // see R20
				LFC_IDX_SIZE: rd = {q_reg.enh, 3'h0, q_reg.len};
				default: rd = 8'h00;
			endcase
		end
		// Sleep warning is kept internally but reads back together with its neighbours
		if (lnk.acc_sel && q_reg.index == LFC_IDX_CTRL) begin
			rd[LFC_CTRL_SLEEP] = q_reg.sleep;
		end
		if (acc && !lnk.acc_write) begin
			q_next.rdata = rd;
		end
		if (acc && lnk.acc_write && !lnk.acc_sel) begin
			q_next.index = wd; // see R24
		end

		// Software writes other than stop; their clears come first so hardware sets below win
		if (wwin && in_data) begin
			q_next.data[pos] = wd; // see R01
		end
		if (wwin && q_reg.index == LFC_IDX_SIZE) begin
			q_next.enh = wd[LFC_SIZE_ENH]; // see R21
			q_next.len = wd[3:0];
		end
		if (wwin && q_reg.index == LFC_IDX_CTRL) begin
			q_next.dir = wd[LFC_CTRL_DIR]; // see R04
			q_next.sleep = wd[LFC_CTRL_SLEEP]; // see R03
			if (wd[LFC_CTRL_IRQ_CLR]) begin
				q_next.irq = 1'b0; // see R06
			end
			if (wd[LFC_CTRL_FAULT_CLR]) begin
				q_next.err = 1'b0; // see R07
				q_next.fault = 5'h00;
			end
			if (slave && wd[LFC_CTRL_ACK]) begin
				q_next.ack_pulse = 1'b1; // see R05
				q_next.acked = 1'b1;
				q_next.identifier_received = 1'b0;
			end
			// Wake and start are refused while an error is still pending
			if (wd[LFC_CTRL_WAKE] && !q_reg.err) begin
				q_next.wake_req = 1'b1; // see R08
			end
			if (!slave && wd[LFC_CTRL_START] && !q_reg.err) begin
				q_next.start_req = 1'b1; // see R09
				q_next.done_flag = 1'b0; // see R16
				q_next.busy = 1'b1;
			end
		end

		// Bus idle timer; only a slave watches for the idle timeout
		if (!slave || bus_active_in || q_reg.sleep) begin
			q_next.idle_cnt = '0;
			q_next.idle_to = 1'b0;
		end else if (q_reg.idle_cnt != IDLE_LIMIT) begin
			q_next.idle_cnt = CW'(q_reg.idle_cnt + 1'b1);
			if (q_next.idle_cnt == IDLE_LIMIT) begin
				q_next.idle_to = 1'b1; // see R11
				q_next.irq = 1'b1;
			end
		end

		// Sync break opens a new frame and ends any suspension
		if (slave && sync_break_in) begin
			q_next.abort = q_reg.busy; // see R12
			q_next.suspended = 1'b0; // see R02
			q_next.busy = 1'b1;
			q_next.done_flag = 1'b0; // see R16
			q_next.identifier_received = 1'b0;
			q_next.acked = 1'b0;
			q_next.wake_seen = 1'b0;
		end
		if (wwin && q_reg.index == LFC_IDX_CTRL && slave && wd[LFC_CTRL_STOP]) begin
			q_next.stop_pulse = 1'b1; // see R02
			q_next.suspended = 1'b1;
			q_next.abort = 1'b1; // see R12
			q_next.acked = 1'b1;
			q_next.identifier_received = 1'b0;
			q_next.busy = 1'b0;
		end
		if (slave && id_received_in && !q_reg.suspended) begin
			q_next.identifier_received = 1'b1; // see R13
			q_next.acked = 1'b0;
			q_next.irq = 1'b1;
		end
		if (frame_done_in && !q_reg.suspended) begin
			q_next.done_flag = 1'b1; // see R16
			q_next.busy = 1'b0;
			q_next.start_req = 1'b0; // see R09
			q_next.irq = 1'b1;
		end
		if (wake_sent_in) begin
			q_next.wake_req = 1'b0; // see R08
			if (!slave) begin
				q_next.done_flag = 1'b1;
				q_next.irq = 1'b1;
			end
		end
		if (wake_rx_in) begin
			q_next.wake_seen = 1'b1; // see R15
			q_next.done_flag = 1'b1;
			q_next.irq = 1'b1;
		end

		// Faults: any new one raises the sticky error flag and stops the frame
		fset[LFC_FAULT_SYNC] = slave && sync_fault_in; // see R17
		fset[LFC_FAULT_PARITY] = slave && parity_fault_in; // see R17
		fset[LFC_FAULT_RESPONSE_TIMEOUT_FAULT] = timeout_in; // see R18
		if (slave && first_byte_done_in && q_reg.identifier_received && !q_next.acked) begin
			fset[LFC_FAULT_RESPONSE_TIMEOUT_FAULT] = 1'b1; // see R19
		end
		fset[LFC_FAULT_CHK] = checksum_fault_in; // see R20
		fset[LFC_FAULT_READBACK] = tx_driving_in && (tx_bit_in != rx_bit_in); // see R20
		if (fset != 5'h00) begin
			q_next.fault = q_next.fault | fset;
			q_next.err = 1'b1; // see R14
			q_next.start_req = 1'b0; // see R09
			q_next.busy = 1'b0;
			q_next.irq = 1'b1;
		end

		// Received bytes from the engine overwrite a same-cycle software write
		if (rx_byte_valid_in && rx_byte_pos_in < 3'(LFC_DATA_BYTES)) begin
			q_next.data[rx_byte_pos_in] = rx_byte_in; // see R01
		end
		// Length decode is registered so the engine never sees a combinational path
		q_next.dlen = lfc_decode_len(q_next.len, frame_id_in); // see R22 R23
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	// ==========================================
	// Outputs
	assign lnk.acc_done = q_reg.done;
	assign lnk.acc_rdata = q_reg.rdata;
	assign lnk.irq = q_reg.irq;
	assign frame_direction_out = q_reg.dir;
	assign master_frame_start_out = q_reg.start_req;
	assign wake_signal_request_out = q_reg.wake_req;
	assign slave_data_ack_out = q_reg.ack_pulse;
	assign stop_pulse_out = q_reg.stop_pulse;
	assign suspended_out = q_reg.suspended;
	assign sleep_warning_out = q_reg.sleep;
	assign enhanced_checksum_select_out = q_reg.enh;
	assign data_len_out = q_reg.dlen;
	assign data_bytes_out = q_reg.data;
endmodule

/* File: hw/lfc_pkg.sv */
// Constants shared by the LIN frame control register block and its AHB-Lite host bridge.
// Assumes one 250 MHz system clock for both ends and an external bus timing engine.
//
// Overview of operation
// R01: Data bytes four to eight, indices 3-7.
// R02: Slave stop write suspends until sync break.
// R03: Software sets sleep warning, clears on wake; here only a command write clears it.
// R04: Direction bit: zero receive, one transmit.
// R05: Slave ack set by software, self-clears.
// R06: Interrupt clear bit clears pending flag.
// R07: Fault clear wipes error flag, fault register.
// R08: Wake request sends wake, then self-clears.
// R09: Master start launches frame, clears at end.
// R10: Status bit seven mirrors bus activity.
// R11: Slave idle four seconds sets idle flag.
// R12: Abort flag on early break or stop.
// R13: Slave identifier received sets data request.
// R14: Error flag sticks until fault clear.
// R15: Wake flag while sending or after receiving.
// R16: Completion flag clears at start, sets done.
// R17: Slave sync tolerance and parity faults.
// R18: Timeout fault for three missing-data cases.
// R19: Ack or stop before first byte ends.
// R20: Checksum and readback faults, top bits zero.
// R21: Size bit seven picks enhanced checksum.
// R22: Length codes 0-8 direct, fifteen uses identifier.
// R23: Identifier bits decode to two, four, eight.
// R24: Index register selects, window register accesses.
package lfc_pkg;
	// ==========================================
	// Indirect register indices
	localparam logic [7:0] LFC_IDX_DATA4 = 8'h03;
	localparam logic [7:0] LFC_IDX_DATA8 = 8'h07;
	localparam logic [7:0] LFC_IDX_CTRL = 8'h08;
	localparam logic [7:0] LFC_IDX_STAT = 8'h09;
	localparam logic [7:0] LFC_IDX_FAULT = 8'h0a;
	localparam logic [7:0] LFC_IDX_SIZE = 8'h0b;
	localparam int LFC_DATA_BYTES = 5;
	localparam logic [7:0] LFC_RESET_BYTE = 8'h00;
	// ==========================================
	// Command bit positions
	localparam int LFC_CTRL_STOP = 7;
	localparam int LFC_CTRL_SLEEP = 6;
	localparam int LFC_CTRL_DIR = 5;
	localparam int LFC_CTRL_ACK = 4;
	localparam int LFC_CTRL_IRQ_CLR = 3;
	localparam int LFC_CTRL_FAULT_CLR = 2;
	localparam int LFC_CTRL_WAKE = 1;
	localparam int LFC_CTRL_START = 0;
	// ==========================================
	// Fault bit positions and size field
	localparam int LFC_FAULT_SYNC = 4;
	localparam int LFC_FAULT_PARITY = 3;
	localparam int LFC_FAULT_RESPONSE_TIMEOUT_FAULT = 2;
	localparam int LFC_FAULT_CHK = 1;
	localparam int LFC_FAULT_READBACK = 0;
	localparam int LFC_SIZE_ENH = 7;
	localparam logic [3:0] LFC_LEN_MAX = 4'h8;
	localparam logic [3:0] LFC_LEN_FROM_ID = 4'hf;
	localparam logic [3:0] LFC_LEN_TWO = 4'h2;
	localparam logic [3:0] LFC_LEN_FOUR = 4'h4;
	localparam logic [3:0] LFC_LEN_EIGHT = 4'h8;
	// ==========================================
	// Timing
	localparam longint unsigned LFC_CLK_HZ = 250_000_000;
	localparam longint unsigned LFC_IDLE_TIMEOUT_S = 4;
	localparam longint unsigned LFC_IDLE_TIMEOUT_CYC = LFC_IDLE_TIMEOUT_S * LFC_CLK_HZ;
	// ==========================================
	// Host bridge byte offsets on AHB-Lite
	localparam logic [3:0] LFC_HOST_INDEX_OFS = 4'h0;
	localparam logic [3:0] LFC_HOST_WINDOW_OFS = 4'h4;
	localparam logic [3:0] LFC_HOST_STATUS_OFS = 4'h8;
endpackage

/* File: hw/lfc_link_if.sv */
// Indirect access link between the AHB-Lite host bridge and the LIN register block.
// Assumes both ends share clk_sys_in; requests are held until acc_done is seen.
`timescale 1ns/1ps
interface lfc_link_if;
	logic acc_valid;
	logic acc_write;
	logic acc_sel;
	logic [7:0] acc_wdata;
	logic acc_done;
	logic [7:0] acc_rdata;
	logic irq;
	modport dev (input acc_valid, input acc_write, input acc_sel, input acc_wdata,
		output acc_done, output acc_rdata, output irq);
	modport host (output acc_valid, output acc_write, output acc_sel, output acc_wdata,
		input acc_done, input acc_rdata, input irq);
endinterface

/* File: hw/lfc_ahb_host.sv */
// AHB-Lite slave bridge: software reaches the indirect index and window through it.
// Assumes a single master, single word transfers, and the LIN block on the link.
`timescale 1ns/1ps
module lfc_ahb_host import lfc_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	output logic irq_out,
	lfc_link_if.host lnk
);
	typedef enum logic [1:0] {H_IDLE, H_LOAD, H_LINK, H_RESP} lfc_host_st_e;
	typedef struct packed {
		lfc_host_st_e st;
		logic write;
		logic sel;
		logic [7:0] wdata;
		logic [31:0] rdata;
	} lfc_host_state_s;

	lfc_host_state_s q_reg;
	lfc_host_state_s q_next;
	logic ready;

	// ==========================================
	// Transfer sequencing; the data phase stalls until the link answers
	assign ready = (q_reg.st == H_IDLE) || (q_reg.st == H_RESP);

	always_comb begin
		logic [3:0] ofs;
		ofs = haddr_in[3:0];
		q_next = q_reg;
		if (ready && hsel_in && htrans_in[1] && hready_in) begin
			if (ofs == LFC_HOST_INDEX_OFS || ofs == LFC_HOST_WINDOW_OFS) begin
				q_next.st = H_LOAD;
				q_next.write = hwrite_in;
				q_next.sel = (ofs == LFC_HOST_WINDOW_OFS); // see R24
			end else begin
				q_next.st = H_IDLE;
				q_next.rdata = (ofs == LFC_HOST_STATUS_OFS) ? {31'h0, lnk.irq} : 32'h0;
			end
		end else begin
			unique case (q_reg.st)
				H_IDLE: q_next.st = H_IDLE;
				H_RESP: q_next.st = H_IDLE;
				H_LOAD: begin
					// Window writes carry software's sleep, ack, stop and start commands
					q_next.wdata = hwdata_in[7:0]; // see R03, R05, R09, R19
					q_next.st = H_LINK;
				end
				H_LINK: begin
					if (lnk.acc_done) begin
						q_next.rdata = {24'h0, lnk.acc_rdata};
						q_next.st = H_RESP;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	assign lnk.acc_valid = (q_reg.st == H_LINK);
	assign lnk.acc_write = q_reg.write;
	assign lnk.acc_sel = q_reg.sel;
	assign lnk.acc_wdata = q_reg.wdata;
	assign hrdata_out = q_reg.rdata;
	assign hreadyout_out = ready;
	assign hresp_out = 1'b0;
	assign irq_out = lnk.irq;
endmodule

/* File: dv/lfc_link_asserts.sv */
// Checker for the indirect link between the AHB-Lite bridge and the LIN register block.
// Assumes one clock domain; the link signals arrive as plain inputs.
`timescale 1ns/1ps
module lfc_link_asserts import lfc_pkg::*; (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire logic acc_sel,
	input wire logic [7:0] acc_wdata,
	input wire logic acc_done,
	input wire logic [7:0] acc_rdata,
	input wire logic irq
);
	// ====================
	// Index shadow, so that window reads can be judged by the register they hit
	logic [7:0] idx_reg;
	wire logic req = acc_valid && !acc_done;
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			idx_reg <= 8'h00;
		end else if (req && acc_write && !acc_sel) begin
			idx_reg <= acc_wdata;
		end
	end
	// ====================
	// Properties
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);
	sequence s_rd(ix);
		req && !acc_write && acc_sel && idx_reg == ix ##1 acc_done;
	endsequence
	property p_answer; req |=> acc_done; endproperty
	a_answer: assert property (p_answer) else $error("link request not answered");
	property p_once; acc_done |=> !acc_done; endproperty
	a_once: assert property (p_once) else $error("link answer longer than one cycle");
	property p_cause; acc_done |-> $past(req); endproperty
	a_cause: assert property (p_cause) else $error("link answer without request");
	property p_hold; req |=> acc_valid && $stable({acc_write, acc_sel, acc_wdata}); endproperty
	a_hold: assert property (p_hold) else $error("link request changed before answer");
	property p_drop; acc_done |=> !acc_valid; endproperty
	a_drop: assert property (p_drop) else $error("link request kept after answer");
	property p_irq_clr; req && acc_write && acc_sel && idx_reg == LFC_IDX_CTRL && acc_wdata[LFC_CTRL_IRQ_CLR]
		|=> !irq;
	endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("pending flag not cleared");
	property p_ctrl; s_rd(LFC_IDX_CTRL) |-> acc_rdata[7] == 1'b0 && acc_rdata[3:2] == 2'b00; endproperty
	a_ctrl: assert property (p_ctrl) else $error("command bits read nonzero");
	property p_fault; s_rd(LFC_IDX_FAULT) |-> acc_rdata[7:5] == 3'b000; endproperty
	a_fault: assert property (p_fault) else $error("fault top bits nonzero");
	property p_size; s_rd(LFC_IDX_SIZE) |-> acc_rdata[6:4] == 3'b000; endproperty
	a_size: assert property (p_size) else $error("size middle bits nonzero");
endmodule

/* File: dv/lin_frame_control_regs_tb.sv */
// Bench: AHB-Lite bridge and LIN register block joined by their link, software driven.
// Assumes the bench plays the bus timing engine through event pulses and levels.
`timescale 1ns/1ps
module lin_frame_control_regs_tb import lfc_pkg::*; ;
	localparam int E_SB = 0, E_ID = 1, E_FD = 2, E_FB = 3, E_SF = 4, E_PF = 5;
	localparam int E_TO = 6, E_CK = 7, E_WS = 8, E_WR = 9, E_RB = 10;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready, hresp, irq;
	logic master = 1'b1;
	logic act = 1'b0;
	logic drv = 1'b0;
	logic txb = 1'b0;
	logic rxb = 1'b0;
	logic [5:0] fid = 6'h00;
	logic [2:0] pos = 3'h0;
	logic [7:0] rxd = 8'h00;
	logic [10:0] ev = 11'h0;
	logic dir, start, wake, slp, enh, susp;
	logic [3:0] len;
	logic [39:0] dbytes;
	logic ackp, stopp;
	int ack_seen = 0;
	int stop_seen = 0;
	int err_count = 0;
	int cmp_count = 0;
	lfc_link_if lnk ();
	lfc_ahb_host u_lfc_ahb_host (.clk_sys_in(clk), .rstn_in(rstn), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
		.hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .irq_out(irq), .lnk(lnk));
	lfc_lin_node #(.IDLE_CYCLES(20)) u_lfc_lin_node (.clk_sys_in(clk), .rstn_in(rstn), .lnk(lnk),
		.master_mode_in(master), .bus_active_in(act), .sync_break_in(ev[E_SB]), .id_received_in(ev[E_ID]),
		.frame_id_in(fid), .frame_done_in(ev[E_FD]), .first_byte_done_in(ev[E_FB]), .sync_fault_in(ev[E_SF]),
		.parity_fault_in(ev[E_PF]), .timeout_in(ev[E_TO]), .checksum_fault_in(ev[E_CK]), .tx_driving_in(drv),
		.tx_bit_in(txb), .rx_bit_in(rxb), .wake_sent_in(ev[E_WS]), .wake_rx_in(ev[E_WR]),
		.rx_byte_valid_in(ev[E_RB]), .rx_byte_pos_in(pos), .rx_byte_in(rxd), .frame_direction_out(dir),
		.master_frame_start_out(start), .wake_signal_request_out(wake), .slave_data_ack_out(ackp),
		.stop_pulse_out(stopp), .suspended_out(susp), .sleep_warning_out(slp),
		.enhanced_checksum_select_out(enh), .data_len_out(len), .data_bytes_out(dbytes));
	lfc_link_asserts u_lfc_link_asserts (.clk_sys_in(clk), .rstn_in(rstn), .acc_valid(lnk.acc_valid),
		.acc_write(lnk.acc_write), .acc_sel(lnk.acc_sel), .acc_wdata(lnk.acc_wdata), .acc_done(lnk.acc_done),
		.acc_rdata(lnk.acc_rdata), .irq(lnk.irq));
	initial begin
		forever #2 clk = ~clk;
	end
	// One-cycle pulses are counted at the edge that ends them
	always @(posedge clk) begin
		if (ackp === 1'b1) begin
			ack_seen <= ack_seen + 1;
		end
		if (stopp === 1'b1) begin
			stop_seen <= stop_seen + 1;
		end
	end
	// ====================
	// Tasks
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	// One single-word transfer; no wait count is assumed, the watchdog cuts a hang
	task automatic ahb(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {28'h0, a};
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] ix, input logic [7:0] v);
		logic [31:0] q;
		ahb(1'b1, LFC_HOST_INDEX_OFS, ix, q);
		ahb(1'b1, LFC_HOST_WINDOW_OFS, v, q);
	endtask
	task automatic ck(input string nm, input logic [7:0] ix, input logic [7:0] m, input logic [7:0] e);
		logic [31:0] q;
		ahb(1'b1, LFC_HOST_INDEX_OFS, ix, q);
		ahb(1'b0, LFC_HOST_WINDOW_OFS, 8'h00, q);
		chk(nm, q & {24'h0, m}, {32'h0, e});
		chk("hresp", hresp, 1'b0);
	endtask
	task automatic fire(input int b);
		@(posedge clk);
		ev[b] <= 1'b1;
		@(posedge clk);
		ev <= 11'h0;
		@(posedge clk);
	endtask
	initial begin
		#100000;
		err_count++;
		$display("watchdog expired");
		give_verdict();
	end
	// ====================
	// Tests
	initial begin
		logic [31:0] q;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 3; i < 12; i++) ck("reset", i[7:0], 8'hff, 8'h00);
		ahb(1'b0, LFC_HOST_STATUS_OFS, 8'h00, q);
		chk("irq_word", q, 32'h0);
		ahb(1'b0, 4'hc, 8'h00, q);
		chk("unmapped", q, 32'h0);
		$display("done reset");
		for (int i = 0; i < 5; i++) wr(8'h03 + i[7:0], 8'ha0 + i[7:0]);
		wr(8'h02, 8'hff);
		ck("resv", 8'h02, 8'hff, 8'h00);
		for (int i = 0; i < 5; i++) begin
			ck("data", 8'h03 + i[7:0], 8'hff, 8'ha0 + i[7:0]);
			chk("data_out", dbytes[i*8 +: 8], 8'ha0 + i[7:0]);
		end
		pos <= 3'h2;
		rxd <= 8'h5a;
		fire(E_RB);
		ck("rx_byte", 8'h05, 8'hff, 8'h5a);
		$display("done data");
		wr(LFC_IDX_SIZE, 8'hff);
		ck("size", LFC_IDX_SIZE, 8'hff, 8'h8f);
		chk("enh", enh, 1'b1);
		for (int c = 0; c < 15; c++) begin
			wr(LFC_IDX_SIZE, c[7:0]);
			chk("len", len, (c < 9) ? c[3:0] : 4'h0);
		end
		chk("classic", enh, 1'b0);
		for (int k = 0; k < 4; k++) begin
			fid <= {k[1:0], 4'h5};
			wr(LFC_IDX_SIZE, 8'h0f);
			chk("len_id", len, (k == 3) ? 4'h8 : (k == 2) ? 4'h4 : 4'h2);
		end
		$display("done size");
		wr(LFC_IDX_CTRL, 8'h60);
		ck("ctrl", LFC_IDX_CTRL, 8'hff, 8'h60);
		chk("dir_sleep", {dir, slp}, 2'b11);
		wr(LFC_IDX_CTRL, 8'h00);
		chk("dir", dir, 1'b0);
		wr(LFC_IDX_CTRL, 8'h01);
		chk("start", start, 1'b1);
		fire(E_FD);
		chk("start_end", start, 1'b0);
		ck("done", LFC_IDX_STAT, 8'h09, 8'h09);
		ahb(1'b0, LFC_HOST_STATUS_OFS, 8'h00, q);
		chk("irq_word", q, 32'h1);
		wr(LFC_IDX_CTRL, 8'h08);
		chk("irq_clr", irq, 1'b0);
		wr(LFC_IDX_CTRL, 8'h01);
		ck("done_clr", LFC_IDX_STAT, 8'h01, 8'h00);
		fire(E_TO);
		chk("start_err", start, 1'b0);
		$display("done master");
		master <= 1'b0;
		fire(E_SF);
		fire(E_PF);
		fire(E_CK);
		{drv, txb, rxb} <= 3'b110;
		@(posedge clk);
		drv <= 1'b0;
		ck("faults", LFC_IDX_FAULT, 8'hff, 8'h1f);
		ck("err", LFC_IDX_STAT, 8'h04, 8'h04);
		master <= 1'b1;
		wr(LFC_IDX_CTRL, 8'h03);
		chk("refused", {start, wake}, 2'b00);
		wr(LFC_IDX_CTRL, 8'h04);
		ck("fault_clr", LFC_IDX_FAULT, 8'hff, 8'h00);
		ck("err_clr", LFC_IDX_STAT, 8'h04, 8'h00);
		wr(LFC_IDX_CTRL, 8'h02);
		fire(E_WS);
		ck("master_wake", LFC_IDX_STAT, 8'h03, 8'h01);
		$display("done faults");
		master <= 1'b0;
		act <= 1'b1;
		fire(E_SB);
		fire(E_ID);
		ck("identifier_received", LFC_IDX_STAT, 8'hb0, 8'h90);
		wr(LFC_IDX_CTRL, 8'h10);
		chk("ack_pulse", ack_seen, 1);
		ck("ack", LFC_IDX_STAT, 8'h10, 8'h00);
		fire(E_SB);
		ck("abort", LFC_IDX_STAT, 8'h20, 8'h20);
		wr(LFC_IDX_CTRL, 8'h80);
		chk("susp", susp, 1'b1);
		chk("stop_pulse", stop_seen, 1);
		fire(E_ID);
		ck("ignored", LFC_IDX_STAT, 8'h10, 8'h00);
		fire(E_SB);
		chk("resume", susp, 1'b0);
		ck("abort_clr", LFC_IDX_STAT, 8'h20, 8'h00);
		fire(E_ID);
		fire(E_FB);
		ck("no_ack", LFC_IDX_FAULT, 8'hff, 8'h04);
		wr(LFC_IDX_CTRL, 8'h04);
		$display("done slave");
		wr(LFC_IDX_CTRL, 8'h02);
		chk("wake", wake, 1'b1);
		ck("waking", LFC_IDX_STAT, 8'h02, 8'h02);
		fire(E_WS);
		chk("wake_end", wake, 1'b0);
		ck("woken", LFC_IDX_STAT, 8'h02, 8'h00);
		fire(E_WR);
		ck("wake_rx", LFC_IDX_STAT, 8'h03, 8'h03);
		act <= 1'b0;
		wr(LFC_IDX_CTRL, 8'h00);
		ck("idle", LFC_IDX_STAT, 8'hc0, 8'h40);
		wr(LFC_IDX_CTRL, 8'h40);
		ck("asleep", LFC_IDX_STAT, 8'h40, 8'h00);
		$display("done wake and idle");
		give_verdict();
	end
endmodule
